// [core/lcu_pkg.sv]
/*
 * Shared constants and types for the upper link-capability fields.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package lcu_pkg;

  localparam int LCU_ADR_W = 8;
  localparam logic [LCU_ADR_W-1:0] LCU_OFF_LINK_CAP = 8'h4C;
  localparam logic [LCU_ADR_W-1:0] LCU_OFF_LOCK_CTRL = 8'h80;

  localparam int LCU_PM_LSB = 10;
  localparam int LCU_L0S_LSB = 12;
  localparam int LCU_L1_LSB = 15;
  localparam int LCU_REFCLK_BIT = 18;
  localparam int LCU_SDR_BIT = 19;
  localparam int LCU_LAR_BIT = 20;
  localparam int LCU_BWN_BIT = 21;
  localparam int LCU_RSV_LSB = 22;
  localparam int LCU_PORT_LSB = 24;
  localparam int LCU_LOCK_BIT = 0;

  localparam logic [1:0] LCU_PM_RST = 2'h3;
  localparam logic [2:0] LCU_L0S_RST = 3'h6;
  localparam logic [2:0] LCU_L1_RST = 3'h2;
  localparam logic LCU_REFCLK_RST = 1'h0;
  localparam logic LCU_LOCK_RST = 1'h0;

  localparam int LCU_PORT_MAX = 23;

  // Exit latencies as reported; the hardware exit time is informational.
  localparam int LCU_CLK_PS = 4000;
  localparam int LCU_L0S_EXIT_PS = 2040000;
  localparam int LCU_L0S_EXIT_CYC = LCU_L0S_EXIT_PS / LCU_CLK_PS;

  // Writable fields in bit order 18:10 of the capability word.
  typedef struct packed {
    logic refclkRemovalOkBit;
    logic [2:0] l1ExitLatencyField;
    logic [2:0] l0sExitLatencyField;
    logic [1:0] pmSupportField;
  } lcu_fields_t;

  localparam lcu_fields_t LCU_FIELDS_RST = '{
    refclkRemovalOkBit: LCU_REFCLK_RST,
    l1ExitLatencyField: LCU_L1_RST,
    l0sExitLatencyField: LCU_L0S_RST,
    pmSupportField: LCU_PM_RST
  };

endpackage

// [core/lcu_field_if.sv]
/*
 * Carrier between the bus front end and the field store.
 * Assumes both ends run on mclk.
 */
`timescale 1ns/1ps
interface lcu_field_if;
  import lcu_pkg::*;

  logic wrEn;
  lcu_fields_t wrVal;
  lcu_fields_t curVal;

  modport store (input wrEn, input wrVal, output curVal);
  modport ctrl (output wrEn, output wrVal, input curVal);
endinterface

// [core/lcu_field_store.sv]
/*
 * Holds the writable capability fields with their reset values.
 * Assumes the writer has already merged byte lanes and applied the lock.
 */
`timescale 1ns/1ps
module lcu_field_store (
  input wire logic mclk,
  input wire logic resetn,
  lcu_field_if.store fld
);
  import lcu_pkg::*;

  lcu_fields_t fields_r;
  lcu_fields_t fields_nxt;

  always_comb begin
    fields_nxt = fields_r;
    if (fld.wrEn) begin
      fields_nxt = fld.wrVal;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fields_r <= LCU_FIELDS_RST;
    end else begin
      fields_r <= fields_nxt;
    end
  end

  assign fld.curVal = fields_r;

endmodule

// [core/lcu_top.sv]
/*
 * Upper link-capability fields of one switch port behind a classic
 * Wishbone slave, plus a write-lock control register.
 * Assumes a single-cycle classic master on mclk and an active-low reset.
 */
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module lcu_top #(
  parameter int unsigned PORT_INDEX = 0
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [lcu_pkg::LCU_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [1:0] pmSupportField,
  output logic [2:0] l0sExitLatencyField,
  output logic [2:0] l1ExitLatencyField,
  output logic refclkRemovalOkBit
);
  import lcu_pkg::*;

  localparam logic [7:0] PORT_IDX = 8'(PORT_INDEX);

  lcu_field_if fld ();

  lcu_field_store u_store (
    .mclk(mclk),
    .resetn(resetn),
    .fld(fld)
  );

  //////////////////////////////////////////////////////////////////////////
  // Bus decode and read word.

  logic req;
  logic hitCap;
  logic hitLock;
  logic [31:0] laneMask;
  logic [31:0] capWord;
  logic [31:0] mergedCap;

  logic ack_r;
  logic ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic lock_r;
  logic lock_nxt;
  logic wrSeen_r;
  logic wrSeen_nxt;

  assign req = wb_cyc_i && wb_stb_i;
  assign hitCap = (wb_adr_i == LCU_OFF_LINK_CAP);
  assign hitLock = (wb_adr_i == LCU_OFF_LOCK_CTRL);

  always_comb begin
    laneMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    capWord = 32'h0000_0000;
    capWord[LCU_REFCLK_BIT:LCU_PM_LSB] = fld.curVal;
    capWord[LCU_SDR_BIT] = 1'b0;
    capWord[LCU_LAR_BIT] = 1'b0;
    capWord[LCU_BWN_BIT] = 1'b0;
    capWord[LCU_RSV_LSB+1:LCU_RSV_LSB] = 2'h0;
    capWord[LCU_PORT_LSB+7:LCU_PORT_LSB] = PORT_IDX;
    mergedCap = (capWord & ~laneMask) | (wb_dat_i & laneMask);
  end

  //////////////////////////////////////////////////////////////////////////
  // Wishbone answer, write lock and field writes.

  // The write lands on the edge where ack is high, as the master expects.
  always_comb begin
    ack_nxt = req && !ack_r;
    dat_nxt = 32'h0000_0000;
    lock_nxt = lock_r;
    wrSeen_nxt = wrSeen_r;
    fld.wrEn = 1'b0;
    fld.wrVal = fld.curVal;
    if (req && !ack_r && !wb_we_i) begin
      if (hitCap) begin
        dat_nxt = capWord;
      end else if (hitLock) begin
        dat_nxt[LCU_LOCK_BIT] = lock_r;
      end
    end
    if (req && ack_r && wb_we_i) begin
      if (hitLock && wb_sel_i[0]) begin
        lock_nxt = wb_dat_i[LCU_LOCK_BIT];
      end
      if (hitCap && !lock_r) begin
        // Only bits 18:10 are stored, so writes to 31:19 fall away.
        fld.wrEn = 1'b1;
        fld.wrVal = mergedCap[LCU_REFCLK_BIT:LCU_PM_LSB];
        wrSeen_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      lock_r <= LCU_LOCK_RST;
      wrSeen_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      lock_r <= lock_nxt;
      wrSeen_r <= wrSeen_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign pmSupportField = fld.curVal.pmSupportField;
  assign l0sExitLatencyField = fld.curVal.l0sExitLatencyField;
  assign l1ExitLatencyField = fld.curVal.l1ExitLatencyField;
  assign refclkRemovalOkBit = fld.curVal.refclkRemovalOkBit;

  //////////////////////////////////////////////////////////////////////////
  // Assertions and covers.

  logic [LCU_ADR_W-1:0] adrAtReq_r;
  logic weAtReq_r;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      adrAtReq_r <= '0;
      weAtReq_r <= 1'b0;
    end else begin
      adrAtReq_r <= wb_adr_i;
      weAtReq_r <= wb_we_i;
    end
  end

  logic capRdAck;
  assign capRdAck = ack_r && !weAtReq_r && (adrAtReq_r == LCU_OFF_LINK_CAP);

  property p_pm_reset;
    @(posedge mclk) disable iff (!resetn)
      !wrSeen_r |-> pmSupportField == 2'h3;
  endproperty
  a_pm_reset: assert property (p_pm_reset)
    else $error("Support field left its reset value without a write.");

  property p_pm_write;
    @(posedge mclk) disable iff (!resetn)
      (req && ack_r && wb_we_i && hitCap && !lock_r && wb_sel_i[1])
      |=> pmSupportField == $past(wb_dat_i[11:10]);
  endproperty
  a_pm_write: assert property (p_pm_write)
    else $error("Support field did not take the written value.");

  property p_l0s_reset;
    @(posedge mclk) disable iff (!resetn)
      !wrSeen_r |-> l0sExitLatencyField == 3'h6;
  endproperty
  a_l0s_reset: assert property (p_l0s_reset)
    else $error("L0s latency field is not 6 before any write.");

  property p_l1_reset;
    @(posedge mclk) disable iff (!resetn)
      !wrSeen_r |-> l1ExitLatencyField == 3'h2 && capWord[17:15] == 3'h2;
  endproperty
  a_l1_reset: assert property (p_l1_reset)
    else $error("L1 latency field is not 2 before any write.");

  property p_refclk_reset;
    @(posedge mclk) disable iff (!resetn)
      !wrSeen_r |-> !refclkRemovalOkBit;
  endproperty
  a_refclk_reset: assert property (p_refclk_reset)
    else $error("Clock removal bit is set before any write.");

  property p_sdr_zero;
    @(posedge mclk) disable iff (!resetn)
      capRdAck |-> !wb_dat_o[19];
  endproperty
  a_sdr_zero: assert property (p_sdr_zero)
    else $error("Surprise-down bit read as one.");

  property p_lar_zero;
    @(posedge mclk) disable iff (!resetn)
      capRdAck |-> !wb_dat_o[20];
  endproperty
  a_lar_zero: assert property (p_lar_zero)
    else $error("Link-active reporting bit read as one.");

  property p_bwn_zero;
    @(posedge mclk) disable iff (!resetn)
      capRdAck |-> !wb_dat_o[21];
  endproperty
  a_bwn_zero: assert property (p_bwn_zero)
    else $error("Bandwidth notification bit read as one.");

  property p_port_index;
    @(posedge mclk) disable iff (!resetn)
      capRdAck |-> wb_dat_o[31:24] == PORT_IDX && PORT_INDEX <= 23;
  endproperty
  a_port_index: assert property (p_port_index)
    else $error("Port index field does not match the port.");

  property p_rsv_zero;
    @(posedge mclk) disable iff (!resetn)
      capRdAck |-> wb_dat_o[23:22] == 2'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("Reserved bits read as nonzero.");

  property p_lock_holds;
    @(posedge mclk) disable iff (!resetn)
      (req && ack_r && wb_we_i && hitCap && lock_r) |=> $stable(fld.curVal);
  endproperty
  a_lock_holds: assert property (p_lock_holds)
    else $error("Locked capability fields changed on a write.");

  property p_ack_one;
    @(posedge mclk) disable iff (!resetn)
      (req && !ack_r) |=> ack_r ##1 !ack_r;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("Ack is not a single cycle one edge after request.");

  c_cap_read: cover property (@(posedge mclk) disable iff (!resetn)
    capRdAck);
  c_cap_write: cover property (@(posedge mclk) disable iff (!resetn)
    fld.wrEn);
  c_locked_write: cover property (@(posedge mclk) disable iff (!resetn)
    req && ack_r && wb_we_i && hitCap && lock_r);

endmodule

// [tb/tb_link_capability_upper_fields.sv]
/*
 * Self-checking bench for the upper link-capability fields.
 * Assumes lcu_top with a classic Wishbone slave that acks after one cycle.
 */
`timescale 1ns/1ps
module tb_link_capability_upper_fields;
  import lcu_pkg::*;

  localparam int unsigned PIDX = 23;
  localparam logic [8:0] FRST = {1'h0, 3'h2, 3'h6, 2'h3};
  localparam logic [LCU_ADR_W-1:0] ADR_NONE = 8'h50;

  logic mclk;
  logic resetn;
  logic wbCyc;
  logic wbStb;
  logic wbWe;
  logic [LCU_ADR_W-1:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatW;
  logic [31:0] wbDatR;
  logic wbAck;
  logic [1:0] pmSupportField;
  logic [2:0] l0sExitLatencyField;
  logic [2:0] l1ExitLatencyField;
  logic refclkRemovalOkBit;
  logic [31:0] rdVal;
  int errorCnt;
  int totalChecks;

  lcu_top #(.PORT_INDEX(PIDX)) dut_u (
    .mclk(mclk),
    .resetn(resetn),
    .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb),
    .wb_we_i(wbWe),
    .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel),
    .wb_dat_i(wbDatW),
    .wb_dat_o(wbDatR),
    .wb_ack_o(wbAck),
    .pmSupportField(pmSupportField),
    .l0sExitLatencyField(l0sExitLatencyField),
    .l1ExitLatencyField(l1ExitLatencyField),
    .refclkRemovalOkBit(refclkRemovalOkBit)
  );

  //////////////////////////////////////////////////////////////////////////

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk32(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One classic cycle; ack and read data are taken at the rising edge
  // where ack is seen high, and the request is released at that edge.
  task automatic wbXfer(input logic we, input logic [LCU_ADR_W-1:0] adr,
                        input logic [3:0] sel, input logic [31:0] wd,
                        output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge mclk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= sel;
    wbDatW <= wd;
    do begin
      @(posedge mclk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (n >= 50) begin
      errorCnt++;
      $display("[FAIL] ack expected 1 seen %b", wbAck);
    end
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  task automatic wr(input logic [LCU_ADR_W-1:0] adr, input logic [3:0] sel,
                    input logic [31:0] wd);
    logic [31:0] d;
    wbXfer(1'b1, adr, sel, wd, d);
  endtask

  // Reads the word and compares it and the field outputs with one state.
  task automatic chkState(input logic [8:0] f);
    logic [31:0] d;
    wbXfer(1'b0, LCU_OFF_LINK_CAP, 4'h0, 32'h0000_0000, d);
    chk32("cap word", {PIDX[7:0], 5'h00, f, 10'h000}, d);
    chk32("field outs", {23'h000000, f}, {23'h000000, refclkRemovalOkBit,
          l1ExitLatencyField, l0sExitLatencyField, pmSupportField});
  endtask

  initial begin
    #8000;
    errorCnt++;
    print_verdict();
  end

  initial begin
    errorCnt = 0;
    totalChecks = 0;
    resetn = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'h0;
    wbDatW = 32'h0000_0000;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    chkState(FRST);
    wr(LCU_OFF_LINK_CAP, 4'hF, 32'hFFFF_FFFF);
    chkState(9'h1FF);
    wr(LCU_OFF_LINK_CAP, 4'hF, 32'h0000_0000);
    chkState(9'h000);
    wr(LCU_OFF_LINK_CAP, 4'h2, 32'hFFFF_FFFF);
    chkState(9'h03F);
    wr(LCU_OFF_LINK_CAP, 4'h4, 32'hFFFF_FFFF);
    chkState(9'h1FF);
    // Locked fields ignore writes until the lock is cleared.
    wr(LCU_OFF_LOCK_CTRL, 4'h1, 32'hFFFF_FFFF);
    wbXfer(1'b0, LCU_OFF_LOCK_CTRL, 4'h0, 32'h0000_0000, rdVal);
    chk32("lock reg", 32'h0000_0001, rdVal);
    wr(LCU_OFF_LINK_CAP, 4'hF, 32'h0000_0000);
    chkState(9'h1FF);
    wr(LCU_OFF_LOCK_CTRL, 4'h1, 32'h0000_0000);
    wr(ADR_NONE, 4'hF, 32'h0000_0000);
    wbXfer(1'b0, ADR_NONE, 4'h0, 32'h0000_0000, rdVal);
    chk32("unmapped", 32'h0000_0000, rdVal);
    chkState(9'h1FF);
    // A second reset in mid-run restores the advertised defaults.
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    chkState(FRST);
    print_verdict();
  end
endmodule
